// ===== cst16_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants and carrier types for the cascaded 16-bit period timer
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Byte address = bank * 0x100 + register index * 4
//////////////////////////////////////////////////////////////////////////////
package cst16_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indexes and the bank each one lives in
  localparam logic [5:0] IDX_LOW_COUNT  = 6'h10;
  localparam logic [5:0] IDX_HIGH_COUNT = 6'h11;
  localparam logic [5:0] IDX_LOW_PERIOD = 6'h14;
  localparam logic [5:0] IDX_HIGH_PERIOD = 6'h15;
  localparam logic [5:0] IDX_FLAGS      = 6'h16;
  localparam logic [5:0] IDX_ENABLES    = 6'h17;
  localparam logic [5:0] IDX_CTRL_FIRST = 6'h16;
  localparam logic [5:0] IDX_CTRL_SECOND = 6'h17;
  localparam logic [1:0] BANK_FLAGS     = 2'h1;
  localparam logic [1:0] BANK_TIMER     = 2'h2;
  localparam logic [1:0] BANK_CTRL      = 2'h3;

  // Field positions
  localparam int unsigned BIT_COUNT_SRC  = 0;
  localparam int unsigned BIT_UPPER_SRC  = 1;
  localparam int unsigned BIT_CASCADE    = 3;
  localparam int unsigned BIT_LOW_RUN    = 0;
  localparam int unsigned BIT_HIGH_RUN   = 1;
  localparam int unsigned BIT_MATCH_FLAG = 4;

  // Reset values and masks
  localparam logic [7:0] RST_FLAGS   = 8'h02;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_PERIOD  = 8'h00;
  localparam logic [7:0] CTRL2_WMASK = 8'h3f;
  localparam logic [7:0] MATCH_MASK  = 8'h10;

  // Instruction cycle is four oscillator clocks
  localparam logic [1:0] PHASE_LAST  = 2'h3;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata;
  } cst16_apb_req_t;

endpackage

// ===== cst16_timer.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two 8-bit timers cascaded into one 16-bit period timer, APB slave
// Assumes: clk_i is the oscillator clock; instruction cycle = 4 clocks
// Notes:   Interrupt status is read-to-clear; mask is peripheral_enables
// What this block does
// - Cascade select plus high run enable joins both count bytes; high byte is upper half
// - Cascaded counter counts up until it equals the 16-bit period
// - Next count clock after a match loads zero and sets match flag
// - Only the low source select picks the clock; upper select ignored
// - Source select clear: count once per instruction cycle, clock / 4
// - Source select set: count once per falling edge on count pin
// - Count pin sampled twice per instruction cycle, adding latency
// - Cascade select and both run enables cascade; low only counts low byte; low off stops
//////////////////////////////////////////////////////////////////////////////
//
// The APB register port was decided locally.
`timescale 1ns/1ns

module cst16_timer
  import cst16_pkg::*;
(
  input  wire logic                      clk_i,          // Oscillator clock
  input  wire logic                      rst_i,          // Sync reset, high
  input  wire cst16_pkg::cst16_apb_req_t apb_i,          // APB request
  output logic [cst16_pkg::DATA_W-1:0]   prdata_o,       // APB read data
  output logic                           pready_o,       // APB ready
  output logic                           pslverr_o,      // APB error
  input  wire logic                      ext_count_pin_i, // External count pin
  output logic                           irq_o           // Interrupt level
);
  import cst16_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] low_count_byte;
  logic [7:0] high_count_byte;
  logic [7:0] low_period_byte;
  logic [7:0] high_period_byte;
  logic [7:0] peripheral_flags;
  logic [7:0] peripheral_enables;
  logic [7:0] timer_control_first;
  logic [7:0] timer_control_second;
  logic [7:0] rd_snap;
  logic       rd_hit;
  logic [1:0] phase;
  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       pin_level;
  logic       pin_level_q;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire [1:0] bank       = apb_i.paddr[9:8];
  wire [5:0] idx        = apb_i.paddr[7:2];
  wire       setup      = apb_i.psel && !apb_i.penable;
  wire       access     = apb_i.psel && apb_i.penable;
  wire       wr         = access && apb_i.pwrite;
  wire       rd         = access && !apb_i.pwrite;
  wire       top_zero   = (apb_i.paddr[ADDR_W-1:10] == '0) &&
                          (apb_i.paddr[1:0] == 2'h0);
  wire       sel_lcnt   = top_zero && bank == BANK_TIMER && idx == IDX_LOW_COUNT;
  wire       sel_hcnt   = top_zero && bank == BANK_TIMER && idx == IDX_HIGH_COUNT;
  wire       sel_lper   = top_zero && bank == BANK_TIMER && idx == IDX_LOW_PERIOD;
  wire       sel_hper   = top_zero && bank == BANK_TIMER && idx == IDX_HIGH_PERIOD;
  wire       sel_flags  = top_zero && bank == BANK_FLAGS && idx == IDX_FLAGS;
  wire       sel_en     = top_zero && bank == BANK_FLAGS && idx == IDX_ENABLES;
  wire       sel_ctrl1  = top_zero && bank == BANK_CTRL && idx == IDX_CTRL_FIRST;
  wire       sel_ctrl2  = top_zero && bank == BANK_CTRL && idx == IDX_CTRL_SECOND;
  wire       mapped     = sel_lcnt || sel_hcnt || sel_lper || sel_hper ||
                          sel_flags || sel_en || sel_ctrl1 || sel_ctrl2;
  wire [7:0] wbyte      = apb_i.pwdata[7:0];

  wire [7:0] rd_mux = sel_lcnt  ? low_count_byte :
                      sel_hcnt  ? high_count_byte :
                      sel_lper  ? low_period_byte :
                      sel_hper  ? high_period_byte :
                      sel_flags ? peripheral_flags :
                      sel_en    ? peripheral_enables :
                      sel_ctrl1 ? timer_control_first :
                      sel_ctrl2 ? timer_control_second : RST_ZERO;

  // No wait state: data is captured in setup so prdata comes from a flop
  assign pready_o  = access;
  assign pslverr_o = access && !mapped;

  //////////////////////////////////////////////////////////////////////////
  // Control fields
  wire cascade_select      = timer_control_first[BIT_CASCADE];
  wire count_source_select = timer_control_first[BIT_COUNT_SRC];
  wire upper_source_select = timer_control_first[BIT_UPPER_SRC];
  wire low_run_enable      = timer_control_second[BIT_LOW_RUN];
  wire high_run_enable     = timer_control_second[BIT_HIGH_RUN];
  wire period_match_flag   = peripheral_flags[BIT_MATCH_FLAG];
  wire period_match_enable = peripheral_enables[BIT_MATCH_FLAG];

  //////////////////////////////////////////////////////////////////////////
  // Count clock sources
  wire instr_tick  = (phase == PHASE_LAST);
  wire sample_slot = !phase[0];
  wire ext_fall    = pin_level_q && !pin_level;
  // Upper source select has no say here
  wire src_tick    = count_source_select ? ext_fall : instr_tick;
  wire tick        = low_run_enable && src_tick;
  wire cascaded    = cascade_select && high_run_enable;

  //////////////////////////////////////////////////////////////////////////
  // Counter datapath
  wire [15:0] count16  = {high_count_byte, low_count_byte};
  wire [15:0] period16 = {high_period_byte, low_period_byte};
  wire        match16  = (count16 == period16);
  wire        match8   = (low_count_byte == low_period_byte);
  wire        match    = cascaded ? match16 : match8;
  wire [15:0] inc16    = 16'(count16 + 16'h0001);
  wire [7:0]  inc8     = 8'(low_count_byte + 8'h01);
  wire [15:0] step16   = match16 ? 16'h0000 : inc16;
  wire [7:0]  step8    = match8 ? RST_ZERO : inc8;
  wire        set_flag = tick && match;

  wire wr_lcnt = wr && sel_lcnt;
  wire wr_hcnt = wr && sel_hcnt;

  wire [7:0] next_low  = wr_lcnt ? wbyte :
                         !tick   ? low_count_byte :
                         cascaded ? step16[7:0] : step8;
  wire [7:0] next_high = wr_hcnt ? wbyte :
                         (tick && cascaded) ? step16[15:8] : high_count_byte;

  // Only the match bit is read-to-clear; set wins over clear
  wire [7:0] clr_mask   = (rd && rd_hit) ? (rd_snap & MATCH_MASK) : RST_ZERO;
  wire [7:0] set_mask   = set_flag ? MATCH_MASK : RST_ZERO;
  wire [7:0] next_flags = (peripheral_flags & ~clr_mask) | set_mask;

  assign irq_o = period_match_flag && period_match_enable;

  //////////////////////////////////////////////////////////////////////////
  // Phase counter and pin synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase       <= 2'h0;
      sync1       <= 1'b1;
      sync2       <= 1'b1;
      sync3       <= 1'b1;
      pin_level   <= 1'b1;
      pin_level_q <= 1'b1;
    end
    else
    begin
      phase       <= 2'(phase + 2'h1);
      sync1       <= ext_count_pin_i;
      sync2       <= sync1;
      sync3       <= sync2;
      pin_level_q <= pin_level;
      // Taken only at the two sample slots of an instruction cycle
      if (sample_slot && sync2 == sync3)
        pin_level <= sync3;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter bytes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_count_byte  <= RST_ZERO;
      high_count_byte <= RST_ZERO;
    end
    else
    begin
      low_count_byte  <= next_low;
      high_count_byte <= next_high;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_period_byte      <= RST_PERIOD;
      high_period_byte     <= RST_PERIOD;
      peripheral_enables   <= RST_ZERO;
      timer_control_first  <= RST_ZERO;
      timer_control_second <= RST_ZERO;
      peripheral_flags     <= RST_FLAGS;
    end
    else
    begin
      peripheral_flags <= next_flags;
      if (wr && sel_lper)
        low_period_byte <= wbyte;
      if (wr && sel_hper)
        high_period_byte <= wbyte;
      if (wr && sel_en)
        peripheral_enables <= wbyte;
      if (wr && sel_ctrl1)
        timer_control_first <= wbyte;
      if (wr && sel_ctrl2)
        timer_control_second <= wbyte & CTRL2_WMASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read capture in setup phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prdata_o <= '0;
      rd_snap  <= RST_ZERO;
      rd_hit   <= 1'b0;
    end
    else if (setup)
    begin
      prdata_o <= {24'h000000, rd_mux};
      rd_snap  <= rd_mux;
      rd_hit   <= sel_flags && !apb_i.pwrite;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cascade_tick;
    tick && cascaded && !wr_lcnt && !wr_hcnt;
  endsequence

  sequence s_quiet_phases;
    !instr_tick [*3];
  endsequence

  sequence s_ext_step;
    tick && cascaded && count_source_select && ext_fall && !wr_lcnt && !wr_hcnt;
  endsequence

  AST_CARRY_INTO_HIGH: assert property (
    s_cascade_tick ##0 (low_count_byte == 8'hff) ##0 !match16
    |=> high_count_byte == 8'($past(high_count_byte) + 8'h01))
    else $error("Low byte wrap did not carry into high byte");

  AST_COUNT_UP: assert property (
    s_cascade_tick ##0 !match16 |=> count16 == 16'($past(count16) + 16'h0001))
    else $error("Cascaded count did not step by one");

  AST_WRAP_AND_FLAG: assert property (
    s_cascade_tick ##0 match16 |=> count16 == 16'h0000 && period_match_flag)
    else $error("Match did not wrap to zero and set flag");

  AST_UPPER_SEL_IGNORED: assert property (
    low_run_enable && !count_source_select && upper_source_select
    |-> tick == instr_tick)
    else $error("Upper source select changed the count clock");

  AST_INSTR_RATE: assert property (
    instr_tick |=> s_quiet_phases ##1 instr_tick)
    else $error("Instruction tick not once every four clocks");

  AST_EXT_SOURCE: assert property (
    low_run_enable && count_source_select |-> tick == ext_fall)
    else $error("External source did not follow pin falling edges");

  AST_PIN_LATENCY: assert property (
    $fell(ext_count_pin_i) ##1 !ext_count_pin_i [*7] |-> ##[0:1] !pin_level)
    else $error("Held pin low not seen within latency bound");

  AST_STOPPED: assert property (
    !low_run_enable && !wr_lcnt && !wr_hcnt |=> $stable(count16))
    else $error("Counter moved with low run enable clear");

  AST_LOW_ONLY: assert property (
    tick && !high_run_enable && !wr_hcnt |=> $stable(high_count_byte))
    else $error("High byte moved with only low run enabled");

  AST_FLAG_STICKY: assert property (
    period_match_flag && !(rd && rd_hit) |=> period_match_flag)
    else $error("Match flag dropped without a clearing read");

  AST_IRQ_LEVEL: assert property (
    set_flag && period_match_enable && !(wr && sel_en) |=> irq_o)
    else $error("Enabled match did not raise the interrupt");

  AST_EXT_STEP: assert property (
    s_ext_step ##0 !match16 |=> count16 == 16'($past(count16) + 16'h0001))
    else $error("Pin falling edge did not step the counter");

  AST_PIN_SLOTS: assert property (
    !sample_slot |=> $stable(pin_level))
    else $error("Pin level taken outside a sample slot");

  AST_LOW_WRAP: assert property (
    tick && !cascaded && match8 && !wr_lcnt
    |=> low_count_byte == RST_ZERO && period_match_flag)
    else $error("Low-only counter did not wrap at its period");

  AST_READ_CLEARS: assert property (
    rd && rd_hit && rd_snap[BIT_MATCH_FLAG] && !set_flag |=> !period_match_flag)
    else $error("Reading the flags did not clear the match flag");

endmodule

// ===== cst16_pin_src.sv
////////////////////////////////////////
// Purpose: Clock source driving the external count pin
// Assumes: The pin has a weak pull-up, so idle is high
// Notes:   A low phase is always finished before going idle
////////////////////////////////////////
`timescale 1ns/1ns

module cst16_pin_src
(
  input  wire logic       clk_i,  // Bench clock
  input  wire logic       run_i,  // Make falling edges
  input  wire logic [3:0] half_i, // Clocks per pin phase
  output logic            pin_o,  // Count pin
  output logic [7:0]      falls_o // Falling edges made
);
  logic [3:0] cnt     = 4'h0;
  logic       pin_q   = 1'b1;
  logic [7:0] falls_q = 8'h00;

  assign pin_o   = pin_q;
  assign falls_o = falls_q;

  // Phases never shorter than half_i clocks, so no pulse is too short
  always @(posedge clk_i)
  begin
    cnt <= (cnt == half_i - 4'h1) ? 4'h0 : cnt + 4'h1;
    if (cnt == half_i - 4'h1)
    begin
      pin_q <= ~(pin_q & run_i);
      if (pin_q & run_i)
        falls_q <= falls_q + 8'h01;
    end
  end
endmodule

// ===== testbench.sv
////////////////////////////////////////
// Purpose: Self-checking bench for the cascaded 16-bit period timer
// Assumes: Tick phase is unknown here, so elapsed times get a window
// Notes:   Transfers are separated by one idle cycle
////////////////////////////////////////
`timescale 1ns/1ns

module testbench;
  import cst16_pkg::*;

  localparam logic [11:0] A_LC = {2'b00, BANK_TIMER, IDX_LOW_COUNT, 2'b00};
  localparam logic [11:0] A_HC = {2'b00, BANK_TIMER, IDX_HIGH_COUNT, 2'b00};
  localparam logic [11:0] A_LP = {2'b00, BANK_TIMER, IDX_LOW_PERIOD, 2'b00};
  localparam logic [11:0] A_HP = {2'b00, BANK_TIMER, IDX_HIGH_PERIOD, 2'b00};
  localparam logic [11:0] A_FL = {2'b00, BANK_FLAGS, IDX_FLAGS, 2'b00};
  localparam logic [11:0] A_EN = {2'b00, BANK_FLAGS, IDX_ENABLES, 2'b00};
  localparam logic [11:0] A_C1 = {2'b00, BANK_CTRL, IDX_CTRL_FIRST, 2'b00};
  localparam logic [11:0] A_C2 = {2'b00, BANK_CTRL, IDX_CTRL_SECOND, 2'b00};

  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  cst16_apb_req_t    req = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              pin;
  logic              irq;
  logic              run = 1'b0;
  logic [3:0]        half = 4'h4;
  logic [7:0]        falls;
  logic [7:0]        v;
  logic              err;
  int                fail_count = 0;
  int                n_compared = 0;
  int                n;

  always #50 clk_i = ~clk_i;

  cst16_timer u_cst16_timer (.clk_i(clk_i), .rst_i(rst_i), .apb_i(req), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_count_pin_i(pin), .irq_o(irq));
  cst16_pin_src u_cst16_pin_src (.clk_i(clk_i), .run_i(run), .half_i(half), .pin_o(pin),
    .falls_o(falls));

  ////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Entered just after a rising edge; returns one idle cycle after the access
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    int k = 0;
    req <= '{1'b1, 1'b0, wr, a, {24'h0, wd}};
    @(posedge clk_i);
    req.penable <= 1'b1;
    // Answer and read data are taken at the edge that samples pready high
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    v = prdata[7:0];
    err = pslverr;
    req <= '0;
    @(posedge clk_i);
    if (k >= 20)
    begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic rc(input logic [11:0] a, input string nm, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, e, v);
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (irq !== 1'b1 && n < lim);
    @(posedge clk_i);
    if (n >= lim)
    begin
      fail_count++;
      end_sim();
    end
  endtask

  ////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rc(A_FL, "flags reset", RST_FLAGS);
    rc(A_EN, "enables reset", 8'h00);
    rc(A_C1, "ctrl_first reset", 8'h00);
    rc(A_C2, "ctrl_second reset", 8'h00);
    xfer(1'b1, 12'h000, 8'h55);
    chk("unmapped error", 8'h01, {7'h0, err});
    rc(12'h000, "unmapped data", 8'h00);
    xfer(1'b1, A_FL, 8'hff);
    chk("mapped error", 8'h00, {7'h0, err});
    rc(A_FL, "flags after write", 8'h02);
    xfer(1'b1, A_C2, 8'hfc);
    rc(A_C2, "ctrl_second bits", 8'h3c);
    xfer(1'b1, A_C2, 8'h02);
    xfer(1'b1, A_LC, 8'h10);
    repeat (40) @(posedge clk_i);
    rc(A_LC, "stopped low", 8'h10);
    // 0x00fd to 0x02fd: a low-only wrap would come at once instead
    xfer(1'b1, A_LC, 8'hfd);
    xfer(1'b1, A_HC, 8'h00);
    xfer(1'b1, A_LP, 8'hfd);
    xfer(1'b1, A_HP, 8'h02);
    xfer(1'b1, A_EN, 8'h10);
    xfer(1'b1, A_C1, 8'h0a);
    xfer(1'b1, A_C2, 8'h03);
    wait_irq(2200);
    chk("wrap time", 8'h01, {7'h0, n >= 2049 && n <= 2052});
    xfer(1'b1, A_C2, 8'h00);
    rc(A_LC, "low after wrap", 8'h00);
    rc(A_HC, "high after wrap", 8'h00);
    xfer(1'b1, A_EN, 8'h00);
    chk("irq masked", 8'h00, {7'h0, irq});
    rc(A_FL, "flag sticky", 8'h12);
    rc(A_FL, "flag cleared", 8'h02);
    xfer(1'b1, A_EN, 8'h10);
    chk("irq after clear", 8'h00, {7'h0, irq});
    xfer(1'b1, A_LC, 8'hfd);
    xfer(1'b1, A_C2, 8'h01);
    wait_irq(40);
    chk("low-only wrap time", 8'h01, {7'h0, n >= 1 && n <= 4});
    xfer(1'b1, A_C2, 8'h00);
    rc(A_HC, "high held", 8'h00);
    rc(A_FL, "low-only flag", 8'h12);
    xfer(1'b1, A_LP, 8'hff);
    xfer(1'b1, A_HP, 8'hff);
    xfer(1'b1, A_LC, 8'h00);
    xfer(1'b1, A_C1, 8'h09);
    xfer(1'b1, A_C2, 8'h03);
    // Fast then slow pin source; idle pin between bursts must not count
    for (int i = 0; i < 2; i++)
    begin
      half <= (i == 0) ? 4'h4 : 4'h9;
      run <= 1'b1;
      n = 0;
      while (falls !== 8'(5 * (i + 1)) && n < 200)
      begin
        @(posedge clk_i);
        n++;
      end
      run <= 1'b0;
      if (n >= 200)
      begin
        fail_count++;
        end_sim();
      end
      repeat (20) @(posedge clk_i);
      rc(A_LC, "pin counts", 8'(5 * (i + 1)));
    end
    end_sim();
  end
endmodule
